// ### rtl/i2cm_pkg.sv
// i2cm_pkg: register indices, field layout, reset values and rate counts of the i2c master.
// assumes a word-addressed avalon-mm slave; byte address is four times the index.
`default_nettype none

package i2cm_pkg;
	// register indices
	localparam logic [7:0] CTRL_IDX = 8'hE1;
	localparam logic [7:0] DATA_IDX = 8'hE2;
	localparam logic [7:0] IRQ_STAT_IDX = 8'hF0;
	localparam logic [7:0] IRQ_EN_IDX = 8'hF1;
	localparam logic [7:0] IRQ_CLR_IDX = 8'hF2;
	// control register field positions
	localparam logic [2:0] EN_BIT = 3'h7;
	localparam logic [2:0] ACKO_BIT = 3'h6;
	localparam logic [2:0] FLAG_BIT = 3'h5;
	localparam logic [2:0] START_BIT = 3'h3;
	localparam logic [2:0] STOP_BIT = 3'h2;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h04;
	localparam logic [7:0] DATA_RST = 8'h00;
	// quarter scl period in clocks for each rate code
	localparam logic [6:0] QTR_R0 = 7'h01;
	localparam logic [6:0] QTR_R1 = 7'h04;
	localparam logic [6:0] QTR_R2 = 7'h10;
	localparam logic [6:0] QTR_R3 = 7'h40;
	// bit counter value of the acknowledge slot
	localparam logic [3:0] ACK_SLOT = 4'h8;
	// interrupt events
	localparam int EV_NUM = 3;
	// one-hot bus sequencer states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_START = 5'h02,
		ST_HOLD = 5'h04,
		ST_BIT = 5'h08,
		ST_STOP = 5'h10
	} i2cm_state_t;
endpackage

`default_nettype wire

// ### rtl/i2cm_rate_div.sv
// i2cm_rate_div: quarter-period strobe for the scl generator.
// assumes run drops whenever the sequencer waits, so each phase starts fresh.
`default_nettype none

module i2cm_rate_div (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic run,
	input wire logic [1:0] rate_sel,
	// one-cycle quarter strobe
	output logic tick
);
	logic [6:0] cnt_reg;
	logic [6:0] qtr;
	logic [6:0] gap_reg;
	logic [1:0] rate_seen_reg;
	logic seen_reg;

	// quarter length per rate code
	always_comb
	begin
		case (rate_sel)
			2'h0: qtr = i2cm_pkg::QTR_R0;
			2'h1: qtr = i2cm_pkg::QTR_R1;
			2'h2: qtr = i2cm_pkg::QTR_R2;
			default: qtr = i2cm_pkg::QTR_R3;
		endcase
	end

	// >= keeps a rate change mid-run from wrapping the counter
	assign tick = run && (cnt_reg >= qtr - 7'h01);

	// free count while running
	always_ff @(posedge clk)
	begin
		if (!rst_n || !run || tick)
			cnt_reg <= 7'h00;
		else
			cnt_reg <= cnt_reg + 7'h01;
	end

	// helper: clocks between strobes at a steady rate
	always_ff @(posedge clk)
	begin
		if (!rst_n || !run)
		begin
			gap_reg <= 7'h01;
			seen_reg <= 1'b0;
			rate_seen_reg <= 2'h0;
		end
		else if (tick)
		begin
			gap_reg <= 7'h01;
			seen_reg <= 1'b1;
			rate_seen_reg <= rate_sel;
		end
		else
			gap_reg <= gap_reg + 7'h01;
	end

	a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
		tick && seen_reg && rate_seen_reg == rate_sel |-> gap_reg == qtr)
		else $error("quarter strobe spacing does not match rate code");
endmodule

`default_nettype wire

// ### rtl/i2cm_irq.sv
// i2cm_irq: sticky event status, enable mask and level interrupt.
// assumes events are one-cycle pulses; a set in the clearing cycle wins.
`default_nettype none

module i2cm_irq #(
	parameter int N = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// events and software access
	input wire logic [N-1:0] ev,
	input wire logic en_we,
	input wire logic clr_we,
	input wire logic [N-1:0] wdata,
	// state
	output logic [N-1:0] status,
	output logic [N-1:0] enable,
	output logic irq
);
	// enable mask
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			enable <= '0;
		else if (en_we)
			enable <= wdata;
	end

	// one sticky bit per event
	for (genvar i = 0; i < N; i++)
	begin : g_stat
		always_ff @(posedge clk)
		begin
			if (!rst_n)
				status[i] <= 1'b0;
			else if (ev[i])
				status[i] <= 1'b1;
			else if (clr_we && wdata[i])
				status[i] <= 1'b0;
		end
	end

	assign irq = |(status & enable);
endmodule

`default_nettype wire

// ### rtl/i2cm_master.sv
// i2cm_master: byte-oriented i2c bus master with avalon-mm register access.
// assumes bus inputs are synchronous to clk and external pull-ups on scl and sda.
//
// The implementer's own choice: the Avalon-MM register port.
`default_nettype none

module i2cm_master (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// avalon-mm slave, word addressed
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// open-drain i2c lines
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// interrupt
	output logic irq
);
	i2cm_pkg::i2cm_state_t state_reg;
	logic ack_reg;
	logic acc, wr, wr_ctrl, wr_data, rd_data;
	logic [31:0] readdata_reg;
	logic master_enable_reg;
	logic ack_out_select_reg;
	logic byte_done_flag_reg;
	logic ack_in_status_reg;
	logic start_request_reg;
	logic stop_request_reg;
	logic [1:0] scl_rate_select_reg;
	logic [7:0] shift_reg;
	logic tx_mode_reg, rx_ack_reg, samp_reg;
	logic [3:0] bit_cnt_reg;
	logic [1:0] phase_reg;
	logic scl_oe_reg, sda_oe_reg;
	logic tick, run;
	logic st_idle, st_start, st_hold, st_bit, st_stop;
	logic start_go, rstart_go, stop_go, tx_go, rx_go;
	logic start_done, done_ev, stop_ev, nack_ev;
	logic [i2cm_pkg::EV_NUM-1:0] irq_status, irq_enable;

	// state decode
	assign st_idle = state_reg == i2cm_pkg::ST_IDLE;
	assign st_start = state_reg == i2cm_pkg::ST_START;
	assign st_hold = state_reg == i2cm_pkg::ST_HOLD;
	assign st_bit = state_reg == i2cm_pkg::ST_BIT;
	assign st_stop = state_reg == i2cm_pkg::ST_STOP;

	// bus handshake: one wait state, so readdata is always from a flop
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	assign acc = (avs_read || avs_write) && ack_reg;
	assign wr = acc && avs_write && avs_byteenable[0];
	assign wr_ctrl = wr && avs_address == i2cm_pkg::CTRL_IDX;
	assign wr_data = wr && avs_address == i2cm_pkg::DATA_IDX;
	assign rd_data = acc && avs_read && avs_address == i2cm_pkg::DATA_IDX;
	assign avs_readdata = readdata_reg;

	// sequencer launch conditions; a pending stop or start beats a data access
	assign start_go = st_idle && master_enable_reg && start_request_reg;
	assign stop_go = st_hold && stop_request_reg;
	assign rstart_go = st_hold && !stop_request_reg && start_request_reg;
	assign tx_go = st_hold && !stop_request_reg && !start_request_reg && wr_data;
	assign rx_go = st_hold && !stop_request_reg && !start_request_reg && rd_data;

	// sequence end events
	assign start_done = st_start && tick && phase_reg == 2'h3;
	assign done_ev = st_bit && tick && phase_reg == 2'h3 && bit_cnt_reg == i2cm_pkg::ACK_SLOT;
	assign stop_ev = st_stop && tick && phase_reg == 2'h3;
	assign nack_ev = done_ev && tx_mode_reg && samp_reg;

	// divider only runs while a bus phase is in progress
	assign run = master_enable_reg && (st_start || st_bit || st_stop);

	i2cm_rate_div u_div (
		.clk(clk),
		.rst_n(rst_n),
		.run(run),
		.rate_sel(scl_rate_select_reg),
		.tick(tick)
	);

	i2cm_irq #(
		.N(i2cm_pkg::EV_NUM)
	) u_irq (
		.clk(clk),
		.rst_n(rst_n),
		.ev({nack_ev, stop_ev, done_ev}),
		.en_we(wr && avs_address == i2cm_pkg::IRQ_EN_IDX),
		.clr_we(wr && avs_address == i2cm_pkg::IRQ_CLR_IDX),
		.wdata(avs_writedata[i2cm_pkg::EV_NUM-1:0]),
		.status(irq_status),
		.enable(irq_enable),
		.irq(irq)
	);

	// wait-state flop: accept on the cycle after the request appears
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ack_reg <= 1'b0;
		else
			ack_reg <= (avs_read || avs_write) && !ack_reg;
	end

	// read mux, captured in the wait cycle; unmapped reads give zero
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			readdata_reg <= 32'h0;
		else if (avs_read && !ack_reg)
		begin
			case (avs_address)
				i2cm_pkg::CTRL_IDX: readdata_reg <= {24'h0, master_enable_reg, ack_out_select_reg,
					byte_done_flag_reg, ack_in_status_reg, start_request_reg, stop_request_reg,
					scl_rate_select_reg};
				i2cm_pkg::DATA_IDX: readdata_reg <= {24'h0, shift_reg};
				i2cm_pkg::IRQ_STAT_IDX: readdata_reg <= {29'h0, irq_status};
				i2cm_pkg::IRQ_EN_IDX: readdata_reg <= {29'h0, irq_enable};
				default: readdata_reg <= 32'h0;
			endcase
		end
	end

	// plain control fields
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			master_enable_reg <= i2cm_pkg::CTRL_RST[i2cm_pkg::EN_BIT];
			ack_out_select_reg <= i2cm_pkg::CTRL_RST[i2cm_pkg::ACKO_BIT];
			scl_rate_select_reg <= i2cm_pkg::CTRL_RST[1:0];
		end
		else if (wr_ctrl)
		begin
			master_enable_reg <= avs_writedata[i2cm_pkg::EN_BIT];
			ack_out_select_reg <= avs_writedata[i2cm_pkg::ACKO_BIT];
			scl_rate_select_reg <= avs_writedata[1:0];
		end
	end

	// completion flag: hardware set wins over a software write of 0
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			byte_done_flag_reg <= i2cm_pkg::CTRL_RST[i2cm_pkg::FLAG_BIT];
		else if (done_ev)
			byte_done_flag_reg <= 1'b1;
		else if (wr_ctrl && !avs_writedata[i2cm_pkg::FLAG_BIT])
			byte_done_flag_reg <= 1'b0;
	end

	// acknowledge seen from the slave, only updated on transmitted bytes
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ack_in_status_reg <= 1'b0;
		else if (done_ev && tx_mode_reg)
			ack_in_status_reg <= samp_reg;
	end

	// start and stop requests: software sets, finished START clears both
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			start_request_reg <= i2cm_pkg::CTRL_RST[i2cm_pkg::START_BIT];
			stop_request_reg <= i2cm_pkg::CTRL_RST[i2cm_pkg::STOP_BIT];
		end
		else
		begin
			if (wr_ctrl && avs_writedata[i2cm_pkg::START_BIT])
				start_request_reg <= 1'b1;
			else if (start_done)
				start_request_reg <= 1'b0;
			if (wr_ctrl && avs_writedata[i2cm_pkg::STOP_BIT])
				stop_request_reg <= 1'b1;
			else if (start_done)
				stop_request_reg <= 1'b0;
		end
	end

	// sequencer; disabling drops straight to idle
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			state_reg <= i2cm_pkg::ST_IDLE;
		else if (!master_enable_reg)
			state_reg <= i2cm_pkg::ST_IDLE;
		else
		begin
			case (state_reg)
				i2cm_pkg::ST_IDLE:
					if (start_go)
						state_reg <= i2cm_pkg::ST_START;
				i2cm_pkg::ST_START:
					if (start_done)
						state_reg <= i2cm_pkg::ST_HOLD;
				i2cm_pkg::ST_HOLD:
					if (stop_go)
						state_reg <= i2cm_pkg::ST_STOP;
					else if (rstart_go)
						state_reg <= i2cm_pkg::ST_START;
					else if (tx_go || rx_go)
						state_reg <= i2cm_pkg::ST_BIT;
				i2cm_pkg::ST_BIT:
					if (done_ev)
						state_reg <= i2cm_pkg::ST_HOLD;
				i2cm_pkg::ST_STOP:
					if (stop_ev)
						state_reg <= i2cm_pkg::ST_IDLE;
				default:
					state_reg <= i2cm_pkg::ST_IDLE;
			endcase
		end
	end

	// quarter phase; every sequence ends on phase 3 so it wraps back to 0
	always_ff @(posedge clk)
	begin
		if (!rst_n || !master_enable_reg)
			phase_reg <= 2'h0;
		else if (tick)
			phase_reg <= phase_reg + 2'h1;
	end

	// direction and ack choice, frozen for the whole byte
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tx_mode_reg <= 1'b0;
			rx_ack_reg <= 1'b0;
		end
		else if (tx_go)
			tx_mode_reg <= 1'b1;
		else if (rx_go)
		begin
			tx_mode_reg <= 1'b0;
			rx_ack_reg <= ack_out_select_reg;
		end
	end

	// bit counter: 0..7 data, 8 is the ack slot
	always_ff @(posedge clk)
	begin
		if (!rst_n || tx_go || rx_go || !master_enable_reg)
			bit_cnt_reg <= 4'h0;
		else if (st_bit && tick && phase_reg == 2'h3)
			bit_cnt_reg <= done_ev ? 4'h0 : bit_cnt_reg + 4'h1;
	end

	// sda sampled mid-high of scl
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			samp_reg <= 1'b1;
		else if (st_bit && tick && phase_reg == 2'h2)
			samp_reg <= sda_i;
	end

	// shift register: writes outside a byte load it, msb leaves first;
	// writes mid-byte are dropped so the byte on the wire stays intact
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			shift_reg <= i2cm_pkg::DATA_RST;
		else if (wr_data && !st_bit)
			shift_reg <= avs_writedata[7:0];
		else if (st_bit && tick && phase_reg == 2'h3 && bit_cnt_reg != i2cm_pkg::ACK_SLOT)
			shift_reg <= {shift_reg[6:0], samp_reg};
	end

	// line drivers: oe high pulls the line low, released otherwise
	always_ff @(posedge clk)
	begin
		if (!rst_n || !master_enable_reg)
		begin
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end
		else if (tick)
		begin
			case (state_reg)
				i2cm_pkg::ST_START:
					case (phase_reg)
						2'h0: sda_oe_reg <= 1'b0;
						2'h1: scl_oe_reg <= 1'b0;
						2'h2: sda_oe_reg <= 1'b1;
						default: scl_oe_reg <= 1'b1;
					endcase
				i2cm_pkg::ST_BIT:
					case (phase_reg)
						2'h0:
							if (bit_cnt_reg == i2cm_pkg::ACK_SLOT)
								sda_oe_reg <= !tx_mode_reg && !rx_ack_reg;
							else
								sda_oe_reg <= tx_mode_reg && !shift_reg[7];
						2'h1, 2'h2: scl_oe_reg <= 1'b0;
						default: scl_oe_reg <= 1'b1;
					endcase
				i2cm_pkg::ST_STOP:
					case (phase_reg)
						2'h0: sda_oe_reg <= 1'b1;
						2'h1: scl_oe_reg <= 1'b0;
						default: sda_oe_reg <= 1'b0;
					endcase
				default:
					scl_oe_reg <= scl_oe_reg;
			endcase
		end
	end

	// open drain: only ever drive low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_oe_reg;
	assign sda_oe = sda_oe_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_idle_when_off: assert property (
		!master_enable_reg |=> st_idle && !scl_oe_reg && !sda_oe_reg)
		else $error("master active while disabled");

	a_ack_drive: assert property (
		st_bit && bit_cnt_reg == i2cm_pkg::ACK_SLOT && !tx_mode_reg && !scl_oe_reg
		|-> sda_oe_reg == !rx_ack_reg)
		else $error("receive ack slot does not follow ack_out_select");

	a_flag_set: assert property (
		done_ev |=> byte_done_flag_reg && st_hold && irq_status[0])
		else $error("byte completion did not set the flag");

	a_ack_capture: assert property (
		done_ev && tx_mode_reg |=> ack_in_status_reg == $past(samp_reg))
		else $error("slave acknowledge not captured");

	a_start_cond: assert property (
		st_start && tick && phase_reg == 2'h2 |=> sda_oe_reg && !scl_oe_reg ##[1:70] st_hold)
		else $error("start condition not formed");

	a_stop_cond: assert property (
		st_stop && tick && phase_reg == 2'h2 |=> !sda_oe_reg && !scl_oe_reg ##[1:70] st_idle)
		else $error("stop condition not formed");

	a_write_sends: assert property (
		tx_go |=> st_bit && tx_mode_reg && shift_reg == $past(avs_writedata[7:0]))
		else $error("data write did not start transmission");

	a_read_resumes: assert property (
		rx_go |-> avs_readdata[7:0] == shift_reg ##1 st_bit && !tx_mode_reg)
		else $error("data read did not return byte and resume reception");

	a_sda_stable_high: assert property (
		st_bit && !scl_oe_reg && $past(!scl_oe_reg) |-> $stable(sda_oe_reg))
		else $error("sda moved while scl was high");
endmodule

`default_nettype wire

// ### sim/i2cm_slave_model.sv
// i2cm_slave_model: behavioural i2c slave on the wired-and scl and sda lines.
// assumes pull-ups on both lines; this side never stretches scl.
`default_nettype none

module i2cm_slave_model (
	// wired lines
	input wire logic scl,
	input wire logic sda,
	// behaviour chosen by the bench
	input wire logic rd_mode,
	input wire logic nack,
	input wire logic [7:0] tx_byte,
	// pull request and observations
	output logic sda_pull,
	output logic [7:0] rx_byte,
	output logic mst_ack,
	output int start_cnt,
	output int stop_cnt,
	output time scl_period
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic active;
	logic hold_off;
	time last_rise;

	// quiet state before the first frame
	initial
	begin
		bit_cnt = 4'h0;
		shift = 8'h00;
		active = 1'b0;
		hold_off = 1'b0;
		last_rise = 0;
		start_cnt = 0;
		stop_cnt = 0;
		scl_period = 0;
		rx_byte = 8'h00;
		mst_ack = 1'b0;
	end

	// start and stop are sda edges while scl is high
	always @(sda)
	begin
		if (scl === 1'b1 && sda === 1'b0)
		begin
			start_cnt++;
			active = 1'b1;
			bit_cnt = 4'hF; // the scl fall closing the start wraps this to bit 0
			hold_off = 1'b0;
		end
		// a stop only counts inside a frame, so the lines settling out of reset are not taken for one
		else if (scl === 1'b1 && sda === 1'b1 && active)
		begin
			stop_cnt++;
			active = 1'b0;
		end
	end

	// sample on the high phase: eight data bits msb first, then the ack slot
	always @(posedge scl)
	begin
		scl_period = $time - last_rise;
		last_rise = $time;
		if (bit_cnt < 4'h8)
			shift = {shift[6:0], sda};
		else if (bit_cnt == 4'h8)
		begin
			rx_byte = shift;
			mst_ack = sda;
			hold_off = rd_mode & sda; // a nack from the master ends our sending
		end
	end

	// advance on the low edge, nine clocks per byte
	always @(negedge scl)
	begin
		if (active)
			bit_cnt = (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
	end

	// open-drain drive: data bits when sending, ack or nack when receiving
	assign sda_pull = active && (rd_mode ? (bit_cnt < 4'h8 && !hold_off && !tx_byte[3'h7 - bit_cnt[2:0]])
		: (bit_cnt == 4'h8 && !nack));
endmodule

`default_nettype wire

// ### sim/i2cm_master_tb.sv
// i2cm_master_tb: register-level test of the i2c master against the slave model.
// assumes the word-addressed register map and pull-ups on both lines.
`default_nettype none

module i2cm_master_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic scl_oe;
	logic sda_oe;
	logic scl_o;
	logic sda_o;
	logic sda_pull;
	logic irq;
	logic rd_mode = 1'b0;
	logic nack = 1'b0;
	logic [7:0] tx_byte = 8'h00;
	logic [7:0] rx_byte;
	logic mst_ack;
	int start_cnt;
	int stop_cnt;
	time scl_period;
	int error_cnt = 0;
	int checked = 0;
	logic [7:0] rd;
	// wired-and lines, released level is high
	wire scl_line = scl_oe ? scl_o : 1'b1;
	wire sda_line = (sda_oe ? sda_o : 1'b1) & ~sda_pull;

	i2cm_master i2cm_master_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_i(scl_line), .scl_o(scl_o),
		.scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));

	i2cm_slave_model i2cm_slave_model_i (.scl(scl_line), .sda(sda_line), .rd_mode(rd_mode), .nack(nack),
		.tx_byte(tx_byte), .sda_pull(sda_pull), .rx_byte(rx_byte), .mst_ack(mst_ack),
		.start_cnt(start_cnt), .stop_cnt(stop_cnt), .scl_period(scl_period));

	// 25 MHz clock
	initial
	begin
		forever #20 clk = ~clk;
	end

	// verdict and end of run
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// one access, held until waitrequest is sampled low; a gap edge follows
	task automatic bus_cycle(input logic wr_en, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		avs_address <= idx;
		avs_writedata <= {24'h000000, d};
		avs_write <= wr_en;
		avs_read <= ~wr_en;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 16);
		rd = avs_readdata[7:0];
		if (avs_waitrequest !== 1'b0)
		begin
			error_cnt++;
			end_of_test();
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus_cycle(1'b1, idx, d);
	endtask

	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string what);
		bus_cycle(1'b0, idx, 8'h00);
		check(what, exp, rd);
	endtask

	// poll a register without side effects until the masked bits match
	task automatic wait_reg(input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] want);
		int n;
		n = 0;
		do
		begin
			bus_cycle(1'b0, idx, 8'h00);
			n++;
		end
		while ((rd & mask) !== want && n < 4000);
		if ((rd & mask) !== want)
		begin
			error_cnt++;
			end_of_test();
		end
	endtask

	// main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_chk(i2cm_pkg::CTRL_IDX, 8'h04, "ctrl reset");
		rd_chk(i2cm_pkg::DATA_IDX, 8'h00, "data reset");
		rd_chk(i2cm_pkg::IRQ_STAT_IDX, 8'h00, "status reset");
		rd_chk(8'h10, 8'h00, "unmapped read");
		check("lines idle", 8'h00, {6'h00, scl_oe, sda_oe});
		wr(i2cm_pkg::CTRL_IDX, 8'h08);
		repeat (40) @(posedge clk);
		check("start while disabled", 8'h00, start_cnt[7:0]);
		rd_chk(i2cm_pkg::CTRL_IDX, 8'h0C, "ctrl pending");
		// a write without the low byte lane must leave the control register alone
		avs_byteenable <= 4'hE;
		wr(i2cm_pkg::CTRL_IDX, 8'h80);
		avs_byteenable <= 4'hF;
		rd_chk(i2cm_pkg::CTRL_IDX, 8'h0C, "masked write");
		wr(i2cm_pkg::CTRL_IDX, 8'h88);
		wait_reg(i2cm_pkg::CTRL_IDX, 8'h08, 8'h00);
		check("starts", 8'h01, start_cnt[7:0]);
		rd_chk(i2cm_pkg::CTRL_IDX, 8'h80, "ctrl after start");
		$display("test start done");
		// one written byte per rate code; slowest first
		for (int c = 3; c >= 0; c--)
		begin
			wr(i2cm_pkg::CTRL_IDX, {6'h20, c[1:0]});
			wr(i2cm_pkg::DATA_IDX, 8'hA4 + 8'(c));
			wait_reg(i2cm_pkg::CTRL_IDX, 8'h20, 8'h20);
			check("tx byte", 8'hA4 + 8'(c), rx_byte);
			rd_chk(i2cm_pkg::CTRL_IDX, {6'h28, c[1:0]}, "ctrl after ack");
			check("scl period", 8'(1 << (2 * c)), 8'(scl_period / 160));
		end
		$display("test transmit done");
		// nack from the slave, then interrupt mask and clear
		wr(i2cm_pkg::IRQ_EN_IDX, 8'h04);
		nack <= 1'b1;
		wr(i2cm_pkg::CTRL_IDX, 8'h80);
		wr(i2cm_pkg::DATA_IDX, 8'h3C);
		wait_reg(i2cm_pkg::CTRL_IDX, 8'h20, 8'h20);
		rd_chk(i2cm_pkg::CTRL_IDX, 8'hB0, "nack seen");
		rd_chk(i2cm_pkg::IRQ_STAT_IDX, 8'h05, "status");
		check("irq on", 8'h01, {7'h00, irq});
		wr(i2cm_pkg::IRQ_EN_IDX, 8'h00);
		check("irq masked", 8'h00, {7'h00, irq});
		wr(i2cm_pkg::IRQ_CLR_IDX, 8'h07);
		rd_chk(i2cm_pkg::IRQ_STAT_IDX, 8'h00, "status cleared");
		rd_chk(i2cm_pkg::IRQ_CLR_IDX, 8'h00, "clear reads zero");
		wr(i2cm_pkg::CTRL_IDX, 8'h80);
		rd_chk(i2cm_pkg::CTRL_IDX, 8'h90, "flag cleared");
		// repeated start from the hold state
		wr(i2cm_pkg::CTRL_IDX, 8'h88);
		wait_reg(i2cm_pkg::CTRL_IDX, 8'h08, 8'h00);
		check("restarts", 8'h02, start_cnt[7:0]);
		$display("test interrupt done");
		// two received bytes, ack then nack, then stop
		nack <= 1'b0;
		rd_mode <= 1'b1;
		tx_byte <= 8'h96;
		rd_chk(i2cm_pkg::DATA_IDX, 8'h3C, "byte kept");
		wait_reg(i2cm_pkg::CTRL_IDX, 8'h20, 8'h20);
		check("master ack", 8'h00, {7'h00, mst_ack});
		wr(i2cm_pkg::CTRL_IDX, 8'hC0);
		tx_byte <= 8'h5A;
		rd_chk(i2cm_pkg::DATA_IDX, 8'h96, "rx byte");
		wait_reg(i2cm_pkg::CTRL_IDX, 8'h20, 8'h20);
		check("master nack", 8'h01, {7'h00, mst_ack});
		wr(i2cm_pkg::CTRL_IDX, 8'h84);
		wait_reg(i2cm_pkg::IRQ_STAT_IDX, 8'h02, 8'h02);
		check("stops", 8'h01, stop_cnt[7:0]);
		check("lines released", 8'h00, {6'h00, scl_oe, sda_oe});
		rd_chk(i2cm_pkg::CTRL_IDX, 8'h94, "ctrl after stop");
		rd_chk(i2cm_pkg::DATA_IDX, 8'h5A, "rx byte after stop");
		$display("test receive done");
		end_of_test();
	end
endmodule

`default_nettype wire
